// [logic/low_power_mode_control.sv]
// Low-power mode controller: deep halt, CPU doze and clock-gated modes
// Overview of operation
// (RQ1) Level release: leave halt while release pin high or enabled key active.
// (RQ2) Level release: halt commanded with release active skips straight to warm-up.
// (RQ3) Once warm-up starts, halt is never re-entered.
// (RQ4) Edge-to-level change takes effect only after a release pin rising edge.
// (RQ5) Edge release: halt entered even with pin high; left on rising edge.
// (RQ6) Key inputs must not be relied upon in edge release mode.
// (RQ7) Release enables oscillators per return mode and dual/single clock.
// (RQ8) Warm-up halts operation; length chosen by the warm-up select field.
// (RQ9) Four warm-up lengths per return mode, fast or slow.
// (RQ10) After warm-up, execution resumes after the halt instruction.
// (RQ11) On halt release, prescaler and divider are cleared first; the code clears presc only when warm-up ends.
// (RQ12) Reset pin low ends any low-power mode; restart in fast mode one.
// (RQ13) Doze halts CPU and watchdog; peripherals keep running; state held.
// (RQ14) Doze entered when doze request bit written to one.
// (RQ15) Leaving doze clears the doze bit and restores prior mode.
// (RQ16) Master enable zero: enabled interrupt ends doze, resume inline.
// (RQ17) Master enable one: enabled interrupt ends doze and is serviced.
// (RQ18) Watchdog interrupt just before doze entry blocks the entry.
// (RQ19) Gated modes stop peripheral clocks except the time base timer.
// (RQ20) Gated mode entered when the peripheral clock gate bit is written one.
// (RQ21) Leaving gated mode clears the gate bit and restores prior mode.
// (RQ22) Time base enable at entry sets the time base interrupt latch.
// (RQ23) Main clock select picks fast-clock or slow-clock variants.
// (RQ24) Gated mode released on falling edge of selected time base source.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module low_power_mode_control
  import lpm_pkg::*;
#(
  parameter int unsigned key_count = 4,
  parameter int unsigned tb_taps   = 4
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Wake sources
  input  wire logic                 halt_release_pin,
  input  wire logic [key_count-1:0] key_wakeup_inputs,
  input  wire logic [7:0]           irq_enable_flags,
  input  wire logic [7:0]           irq_latches,
  input  wire logic                 master_irq_enable,
  input  wire logic                 watchdog_irq,
  input  wire logic [tb_taps-1:0]   time_base_sources,
  // Mode outputs
  output logic                      cpu_halted,
  output logic                      periph_clk_gated,
  output logic                      all_halted,
  output logic                      hf_osc_on,
  output logic                      lf_osc_on,
  output logic                      slow_clock_active,
  output logic                      divider_clear,
  output logic                      resume_pulse,
  output logic                      irq_service_req,
  output logic                      time_base_irq
);

  // Address compare shared by the read and the write decode
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : reg_hit

  typedef struct packed {
    mode_t       mode;
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    logic [7:0]  wake;
    logic        level_armed;
    logic        rel_prev;
    logic [1:0]  tb_prev_sel;
    logic        tb_prev;
    logic [1:0]  presc;
    logic        ready;
    logic [31:0] rdata;
    logic        slverr;
    logic        cpu_halted;
    logic        gated;
    logic        all_halted;
    logic        hf_on;
    logic        lf_on;
    logic        slow;
    logic        div_clr;
    logic        resume;
    logic        irq_req;
    logic        tb_irq;
    logic        load;
    logic [15:0] wcount;
  } state_t;
  state_t st_q, st_d;

  logic                 rel_lvl;
  logic [key_count-1:0] key_lvl;
  logic [tb_taps-1:0]   tb_lvl;
  logic                 wt_busy;
  logic                 wt_done;

  pin_sync #(.width(1)) u_rel_sync (
    .clk    (clk),
    .nrst   (nrst),
    .pin_in (halt_release_pin),
    .level  (rel_lvl)
  );

  pin_sync #(.width(key_count + tb_taps)) u_key_sync (
    .clk    (clk),
    .nrst   (nrst),
    .pin_in ({time_base_sources, key_wakeup_inputs}),
    .level  ({tb_lvl, key_lvl})
  );

  warmup_timer u_warm (
    .clk   (clk),
    .nrst  (nrst),
    .load  (st_q.load),
    .count (st_q.wcount),
    .tick  (st_q.slow || (st_q.presc == fast_prescale)),
    .busy  (wt_busy),
    .done  (wt_done)
  );

  logic        apb_wr;
  logic        apb_rd;
  logic        level_mode;
  logic        key_active;
  logic        rel_rise;
  logic        tb_sel_lvl;
  logic        tb_fall;
  logic        any_irq;
  logic [15:0] wut_count;

  always_comb begin
    apb_wr     = psel && penable && pwrite && !st_q.ready;
    apb_rd     = psel && penable && !pwrite && !st_q.ready;
    // Key inputs are active low and only count in level mode
    key_active = |(~key_lvl & st_q.wake[pos_key_en +: key_count]);
    rel_rise   = rel_lvl && !st_q.rel_prev;
    level_mode = st_q.ctrl_one[pos_rel_level] && st_q.level_armed; // [RQ4]
    tb_sel_lvl = tb_lvl[st_q.wake[pos_tb_sel +: 2]];
    tb_fall    = st_q.tb_prev && !tb_sel_lvl
                 && (st_q.tb_prev_sel == st_q.wake[pos_tb_sel +: 2]);
    any_irq    = |(irq_enable_flags & irq_latches);
    case ({st_q.ctrl_one[pos_ret_slow], st_q.ctrl_one[pos_wut +: 2]}) // [RQ9]
      3'b000:  wut_count = wut_fast_long;
      3'b001:  wut_count = wut_fast_mid;
      3'b010:  wut_count = wut_fast_short;
      3'b011:  wut_count = wut_fast_min;
      3'b100:  wut_count = wut_slow_long;
      3'b101:  wut_count = wut_slow_mid;
      3'b110:  wut_count = wut_slow_short;
      default: wut_count = wut_slow_min;
    endcase
  end

  always_comb begin
    st_d          = st_q;
    st_d.ready    = 1'b0;
    st_d.slverr   = 1'b0;
    st_d.load     = 1'b0;
    st_d.resume   = 1'b0;
    st_d.div_clr  = 1'b0;
    st_d.irq_req  = 1'b0;
    st_d.rel_prev = rel_lvl;
    st_d.tb_prev  = tb_sel_lvl;
    st_d.tb_prev_sel = st_q.wake[pos_tb_sel +: 2];
    st_d.presc    = st_q.presc + 2'h1;

    // Register access, one wait state
    if (psel && penable && !st_q.ready) begin
      st_d.ready = 1'b1;
      if (apb_rd) begin
        if (reg_hit(paddr, off_ctrl_one)) begin
          st_d.rdata = {24'h0, st_q.ctrl_one[7:2], 2'b00};
        end else if (reg_hit(paddr, off_ctrl_two)) begin
          st_d.rdata = {24'h0, st_q.ctrl_two & 8'hf4};
        end else if (reg_hit(paddr, off_wake)) begin
          st_d.rdata = {24'h0, st_q.wake};
        end else if (reg_hit(paddr, off_status)) begin
          // Mode, time base latch, warm-up busy, effective level mode
          st_d.rdata = {25'h0, level_mode, wt_busy, st_q.tb_irq, 1'b0, st_q.mode};
        end else begin
          st_d.rdata  = 32'h0;
          st_d.slverr = 1'b1;
        end
      end else if (apb_wr) begin
        st_d.rdata = 32'h0;
        if (reg_hit(paddr, off_ctrl_one)) begin
          // Edge-to-level switch waits for a rising edge of the release pin
          if (pwdata[pos_rel_level] && !st_q.ctrl_one[pos_rel_level]) begin
            st_d.level_armed = 1'b0; // [RQ4]
          end
          st_d.ctrl_one = pwdata[7:0];
        end else if (reg_hit(paddr, off_ctrl_two)) begin
          st_d.ctrl_two = pwdata[7:0];
        end else if (reg_hit(paddr, off_wake)) begin
          st_d.wake = pwdata[7:0];
        end else if (!reg_hit(paddr, off_status)) begin
          st_d.slverr = 1'b1;
        end
      end
    end
    // Set after the write clear, so an edge in the same cycle still arms
    if (rel_rise) begin
      st_d.level_armed = 1'b1; // [RQ4]
    end

    case (st_q.mode)
      st_run: begin
        st_d.slow = st_q.ctrl_two[pos_clk_sel]; // [RQ23]
        if (st_q.ctrl_one[pos_halt_req]) begin
          if (level_mode && (rel_lvl || key_active)) begin
            // Skipped halt still counts on the return clock and clears dividers
            st_d.mode = st_warm; // [RQ2]
            st_d.load = 1'b1;
            st_d.wcount = wut_count;
            st_d.slow = st_q.ctrl_one[pos_ret_slow];
            st_d.div_clr = 1'b1; // [RQ11]
          end else begin
            st_d.mode = st_halt; // [RQ5]
          end
        end else if (st_q.ctrl_two[pos_doze]) begin
          if (watchdog_irq) begin
            st_d.ctrl_two[pos_doze] = 1'b0; // [RQ18]
            st_d.irq_req = 1'b1;
          end else begin
            st_d.mode = st_doze; // [RQ14]
          end
        end else if (st_q.ctrl_two[pos_gate]) begin
          if (watchdog_irq) begin
            st_d.ctrl_two[pos_gate] = 1'b0;
            st_d.irq_req = 1'b1;
          end else begin
            st_d.mode = st_gated; // [RQ20]
            if (st_q.wake[pos_tb_en]) begin
              st_d.tb_irq = 1'b1; // [RQ22]
            end
          end
        end
      end
      st_halt: begin
        // Level mode releases on level; edge mode on rising edge only
        if ((level_mode && (rel_lvl || key_active)) || (!level_mode && rel_rise)) begin
          st_d.mode    = st_warm; // [RQ1] [RQ5]
          st_d.load    = 1'b1;
          st_d.wcount  = wut_count;
          st_d.div_clr = 1'b1; // [RQ11]
          st_d.slow    = st_q.ctrl_one[pos_ret_slow];
        end
      end
      st_warm: begin
        // Pin level is ignored here, so halt cannot be re-entered
        if (wt_done) begin
          st_d.mode = st_run; // [RQ3] [RQ8]
          st_d.ctrl_one[pos_halt_req] = 1'b0;
          // Return mode becomes the main clock, else run would fall back to fast
          st_d.ctrl_two[pos_clk_sel] = st_q.ctrl_one[pos_ret_slow]; // [RQ7]
          st_d.resume  = 1'b1; // [RQ10]
          st_d.presc   = 2'h0;
          st_d.div_clr = 1'b1; // [RQ11]
        end
      end
      st_doze: begin
        if (any_irq) begin
          st_d.mode = st_run; // [RQ15]
          st_d.ctrl_two[pos_doze] = 1'b0;
          st_d.resume  = !master_irq_enable; // [RQ16]
          st_d.irq_req = master_irq_enable; // [RQ17]
        end
      end
      st_gated: begin
        if (tb_fall) begin
          st_d.mode = st_run; // [RQ21] [RQ24]
          st_d.ctrl_two[pos_gate] = 1'b0;
          if (master_irq_enable && irq_enable_flags[7] && st_q.wake[pos_tb_en]) begin
            st_d.irq_req = 1'b1;
          end else begin
            st_d.resume = 1'b1;
          end
        end
      end
      default: st_d.mode = st_run;
    endcase

    // Latch acknowledged by software writing the enable low
    if (apb_wr && reg_hit(paddr, off_wake) && !pwdata[pos_tb_en]
        && !(st_q.mode == st_run && st_d.mode == st_gated)) begin
      st_d.tb_irq = 1'b0;
    end

    st_d.cpu_halted = st_d.mode != st_run; // [RQ13]
    st_d.gated      = st_d.mode == st_gated; // [RQ19]
    st_d.all_halted = st_d.mode == st_halt || st_d.mode == st_warm; // [RQ8]
    // Oscillators: off in halt, return-mode choice in warm-up
    if (st_d.mode == st_halt) begin
      st_d.hf_on = 1'b0;
      st_d.lf_on = 1'b0;
    end else if (st_d.mode == st_warm) begin
      st_d.hf_on = !st_q.ctrl_one[pos_ret_slow] || !st_q.wake[pos_dual_clk]; // [RQ7]
      st_d.lf_on = st_q.wake[pos_dual_clk]; // [RQ7]
    end else begin
      st_d.hf_on = st_q.ctrl_two[pos_hf_osc];
      st_d.lf_on = st_q.ctrl_two[pos_lf_osc];
    end
  end

  // Reset restarts in fast mode one with only the fast oscillator on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q             <= '0; // [RQ12]
      st_q.mode        <= st_run;
      st_q.ctrl_one    <= rst_ctrl_one;
      st_q.ctrl_two    <= rst_ctrl_two;
      st_q.wake        <= rst_wake;
      st_q.level_armed <= 1'b1;
      st_q.hf_on       <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready            = st_q.ready;
  assign prdata            = st_q.rdata;
  assign pslverr           = st_q.slverr;
  assign cpu_halted        = st_q.cpu_halted;
  assign periph_clk_gated  = st_q.gated;
  assign all_halted        = st_q.all_halted;
  assign hf_osc_on         = st_q.hf_on;
  assign lf_osc_on         = st_q.lf_on;
  assign slow_clock_active = st_q.slow;
  assign divider_clear     = st_q.div_clr;
  assign resume_pulse      = st_q.resume;
  assign irq_service_req   = st_q.irq_req;
  assign time_base_irq     = st_q.tb_irq;
endmodule : low_power_mode_control

// [shared/lpm_pkg.sv]
// Constants, register map and types of the low-power mode controller
package lpm_pkg;

  // APB register byte offsets
  localparam logic [7:0] off_ctrl_one    = 8'h00;
  localparam logic [7:0] off_ctrl_two    = 8'h04;
  localparam logic [7:0] off_wake        = 8'h08;
  localparam logic [7:0] off_status      = 8'h0c;

  // system_ctrl_one fields
  localparam int unsigned pos_halt_req   = 7;
  localparam int unsigned pos_rel_level  = 6;
  localparam int unsigned pos_ret_slow   = 5;
  localparam int unsigned pos_wut        = 2;
  // system_ctrl_two fields
  localparam int unsigned pos_hf_osc     = 7;
  localparam int unsigned pos_lf_osc     = 6;
  localparam int unsigned pos_clk_sel    = 5;
  localparam int unsigned pos_doze       = 4;
  localparam int unsigned pos_gate       = 2;
  // wake register fields
  localparam int unsigned pos_key_en     = 0;
  localparam int unsigned pos_dual_clk   = 4;
  localparam int unsigned pos_tb_en      = 5;
  localparam int unsigned pos_tb_sel     = 6;

  // Reset values
  localparam logic [7:0] rst_ctrl_one    = 8'h00;
  localparam logic [7:0] rst_ctrl_two    = 8'h80;
  localparam logic [7:0] rst_wake        = 8'h00;

  // Warm-up counts in ticks of the mode being returned to: fc/4 when fast, one per clock when slow
  localparam logic [15:0] wut_fast_long  = 16'hc000;
  localparam logic [15:0] wut_fast_mid   = 16'h4000;
  localparam logic [15:0] wut_fast_short = 16'h3000;
  localparam logic [15:0] wut_fast_min   = 16'h1000;
  localparam logic [15:0] wut_slow_long  = 16'h6000;
  localparam logic [15:0] wut_slow_mid   = 16'h2000;
  localparam logic [15:0] wut_slow_short = 16'h00c0;
  localparam logic [15:0] wut_slow_min   = 16'h0040;
  // Fast counts use fc/4 ticks so 16 bits suffice (3x2^16/fc = 0xc000 ticks)
  localparam logic [1:0]  fast_prescale  = 2'h3;

  typedef enum logic [2:0] {
    st_run, st_halt, st_warm, st_doze, st_gated
  } mode_t;

endpackage : lpm_pkg

// [logic/pin_sync.sv]
// Three-stage synchroniser; output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned width = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Pins and filtered level
  input  wire logic [width-1:0] pin_in,
  output logic      [width-1:0] level
);
  typedef struct packed {
    logic [width-1:0] s1;
    logic [width-1:0] s2;
    logic [width-1:0] s3;
    logic [width-1:0] lvl;
  } sync_t;
  sync_t st_q, st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < width; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;
endmodule : pin_sync

// [logic/warmup_timer.sv]
// Warm-up down counter, loaded with a count and flagging completion
`timescale 1ns/1ps
module warmup_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Control
  input  wire logic        load,
  input  wire logic [15:0] count,
  input  wire logic        tick,
  // Status
  output logic             busy,
  output logic             done
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } tmr_t;
  tmr_t st_q, st_d;

  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (load) begin
      st_d.cnt  = count;
      st_d.busy = 1'b1;
    end else if (st_q.busy && tick) begin
      if (st_q.cnt <= 16'h0001) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
        st_d.cnt  = 16'h0000;
      end else begin
        st_d.cnt = st_q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = st_q.busy;
  assign done = st_q.done;
endmodule : warmup_timer

// [tb/lpm_checker_assertions.sv]
// Port-level assertions for the low-power mode controller
`timescale 1ns/1ps
module lpm_checker
  import lpm_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Wake sources
  input wire logic [7:0]  irq_enable_flags,
  input wire logic [7:0]  irq_latches,
  input wire logic        watchdog_irq,
  // Mode outputs
  input wire logic        cpu_halted,
  input wire logic        periph_clk_gated,
  input wire logic        all_halted,
  input wire logic        hf_osc_on,
  input wire logic        resume_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic wr_ok = psel && penable && pready && pwrite;
  wire logic pend  = |(irq_enable_flags & irq_latches);

  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_refuse_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  chk_halt_entry: assert property (wr_ok && paddr == off_ctrl_one && pwdata[pos_halt_req]
    && !cpu_halted |-> ##[1:3] all_halted) else $error("halt not entered");
  chk_doze_entry: assert property (wr_ok && paddr == off_ctrl_two && pwdata[pos_doze]
    && !pwdata[pos_gate] && !watchdog_irq && !pend && !cpu_halted |-> ##[1:3] cpu_halted)
    else $error("doze not entered");
  chk_gate_entry: assert property (wr_ok && paddr == off_ctrl_two && pwdata[pos_gate]
    && !pwdata[pos_doze] && !watchdog_irq && !cpu_halted |-> ##[1:3] periph_clk_gated)
    else $error("gated mode not entered");
  chk_warm_halts: assert property (all_halted |-> cpu_halted)
    else $error("cpu running in halt");
  chk_gate_shape: assert property (periph_clk_gated |-> cpu_halted && !all_halted)
    else $error("gated mode shape wrong");
  chk_warm_resume: assert property ($fell(all_halted)
    |-> ##[0:1] (resume_pulse || $past(resume_pulse))) else $error("no resume after warm-up");
  chk_doze_exit: assert property (cpu_halted && !periph_clk_gated && !all_halted && pend
    |-> ##[1:3] !cpu_halted) else $error("doze not left on interrupt");
  chk_reset_state: assert property ($rose(nrst) |-> hf_osc_on && !cpu_halted)
    else $error("bad state after reset");
endmodule : lpm_checker

bind low_power_mode_control lpm_checker u_chk (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .irq_enable_flags(irq_enable_flags), .irq_latches(irq_latches),
  .watchdog_irq(watchdog_irq), .cpu_halted(cpu_halted), .periph_clk_gated(periph_clk_gated),
  .all_halted(all_halted), .hf_osc_on(hf_osc_on), .resume_pulse(resume_pulse)
);

// [tb/wake_partner.sv]
// Far-side model: release pin, key inputs and time base source clocks
`timescale 1ns/1ps
module wake_partner (
  // Clock
  input  wire logic       clk,
  // Requests from the bench
  input  wire logic       rel_cmd,
  input  wire logic [3:0] key_cmd,
  input  wire logic       tb_run,
  // Pins toward the block
  output logic            halt_release_pin,
  output logic [3:0]      key_wakeup_inputs,
  output logic [3:0]      time_base_sources
);
  logic [5:0] div_q = 6'h0;
  // Source clocks stand still unless asked to run
  always @(posedge clk) begin
    if (tb_run) div_q <= div_q + 6'h1;
  end
  // Fastest tap spans several cycles so the input filter can follow it
  assign time_base_sources = div_q[5:2];
  assign halt_release_pin  = rel_cmd;
  assign key_wakeup_inputs = ~key_cmd;
endmodule : wake_partner

// [tb/tb.sv]
// Self-checking bench of the low-power mode controller
`timescale 1ns/1ps
module tb;
  import lpm_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]  paddr, ien, ilat;
  logic [31:0] pwdata, prdata, rdat;
  logic        mie, wdi, rel, rpin, tbr, cpu_h, gated, all_h, hf, lf, slow, dclr, res, svc, tbi;
  logic [3:0]  key, keys, tbs;
  int          n_fail = 0, num_checks = 0, cyc = 0, n_res = 0, n_svc = 0, n_clr = 0;

  low_power_mode_control dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .halt_release_pin(rpin), .key_wakeup_inputs(keys),
    .irq_enable_flags(ien), .irq_latches(ilat), .master_irq_enable(mie),
    .watchdog_irq(wdi), .time_base_sources(tbs), .cpu_halted(cpu_h),
    .periph_clk_gated(gated), .all_halted(all_h), .hf_osc_on(hf), .lf_osc_on(lf),
    .slow_clock_active(slow), .divider_clear(dclr), .resume_pulse(res),
    .irq_service_req(svc), .time_base_irq(tbi));
  wake_partner u_far (.clk(clk), .rel_cmd(rel), .key_cmd(key), .tb_run(tbr),
    .halt_release_pin(rpin), .key_wakeup_inputs(keys), .time_base_sources(tbs));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulse tally and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_res <= n_res + int'(res);
    n_svc <= n_svc + int'(svc);
    n_clr <= n_clr + int'(dclr);
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Waits for a resume or service pulse; t is the cycles spent
  task automatic wait_wake(input int lim, output int t);
    int n0;
    n0 = n_res + n_svc;
    t = 0;
    while (n_res + n_svc == n0 && t < lim) begin
      @(posedge clk);
      t++;
    end
    chk("wake in time", 32'(t < lim), 32'h1);
  endtask : wait_wake

  task automatic t_regs();
    apb(1'b0, off_ctrl_two, 32'h0);
    chk("ctrl_two reset", rdat, {24'h0, rst_ctrl_two});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'(perr), 32'h1);
    chk("unmapped data", rdat, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_edge();
    int t, c0;
    rel <= 1'b1;
    apb(1'b1, off_wake, 32'h0);
    apb(1'b1, off_ctrl_one, 32'h8c);
    repeat (10) @(posedge clk);
    apb(1'b0, off_status, 32'h0);
    chk("edge halt pin high", rdat & 32'h7, 32'h1);
    rel <= 1'b0;
    repeat (8) @(posedge clk);
    c0 = n_clr;
    rel <= 1'b1;
    repeat (8) @(posedge clk);
    chk("single clk hf", 32'({hf, lf}), 32'h2);
    chk("divider clear", 32'(n_clr > c0), 32'h1);
    wait_wake(20000, t);
    t = t + 8;
    chk("fast warm length", 32'(t > 16370 && t < 16400), 32'h1);
    chk("run after warm", 32'(all_h), 32'h0);
    $display("t_edge done");
  endtask : t_edge

  task automatic t_level();
    int t;
    rel <= 1'b0;
    apb(1'b1, off_wake, 32'h11);
    apb(1'b1, off_ctrl_one, 32'h6c);
    apb(1'b0, off_status, 32'h0);
    chk("level not armed", rdat & 32'h40, 32'h0);
    rel <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, off_status, 32'h0);
    chk("level armed", rdat & 32'h40, 32'h40);
    apb(1'b1, off_ctrl_one, 32'hec);
    apb(1'b0, off_status, 32'h0);
    chk("skip to warm", rdat & 32'h7, 32'h2);
    rel <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b0, off_status, 32'h0);
    chk("no halt again", rdat & 32'h7, 32'h2);
    chk("slow return osc", 32'({hf, lf}), 32'h1);
    wait_wake(200, t);
    apb(1'b1, off_ctrl_one, 32'hec);
    apb(1'b0, off_status, 32'h0);
    chk("level halt", rdat & 32'h7, 32'h1);
    key <= 4'h1;
    wait_wake(200, t);
    key <= 4'h0;
    chk("key slow warm", 32'(t >= 64 && t <= 80), 32'h1);
    chk("slow clock", 32'(slow), 32'h1);
    $display("t_level done");
  endtask : t_level

  // m = 0 plain resume, m = 1 service; dz selects doze or gated
  task automatic t_wake(input logic dz);
    int r0, s0, t;
    for (int m = 0; m < 2; m++) begin
      mie <= m[0];
      ien <= dz ? 8'h01 : {m[0], 7'h0};
      apb(1'b1, off_wake, (dz || m[0]) ? 32'h20 : 32'h0);
      apb(1'b1, off_ctrl_two, dz ? 32'hd0 : 32'hc4);
      repeat (2) @(posedge clk);
      chk("entered", 32'({cpu_h, gated}), dz ? 32'h2 : 32'h3);
      if (!dz) chk("tb latch", 32'(tbi), 32'(m[0]));
      r0 = n_res;
      s0 = n_svc;
      if (dz) ilat <= 8'h01;
      else tbr <= 1'b1;
      wait_wake(200, t);
      repeat (2) @(posedge clk);
      ilat <= 8'h00;
      tbr <= 1'b0;
      chk("left", 32'(cpu_h), 32'h0);
      chk("resume", 32'(n_res - r0), 32'(!m[0]));
      chk("service", 32'(n_svc - s0), 32'(m[0]));
      apb(1'b0, off_ctrl_two, 32'h0);
      chk("req bit cleared", rdat & 32'h14, 32'h0);
    end
    $display("t_wake done");
  endtask : t_wake

  task automatic t_dog_reset();
    int s0;
    s0 = n_svc;
    wdi <= 1'b1;
    apb(1'b1, off_ctrl_two, 32'hd0);
    wdi <= 1'b0;
    repeat (2) @(posedge clk);
    chk("dog blocks doze", 32'({cpu_h, 1'b0}) + 32'(n_svc - s0), 32'h1);
    apb(1'b1, off_ctrl_two, 32'hd0);
    repeat (2) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset ends doze", 32'({cpu_h, hf, slow}), 32'h2);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, off_ctrl_two, 32'h0);
    chk("fast after reset", rdat, 32'h80);
    $display("t_dog_reset done");
  endtask : t_dog_reset

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    {nrst, psel, penable, pwrite, mie, wdi, rel, tbr} = 8'h0;
    {paddr, ien, ilat, key} = 28'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_edge(); // keys stay idle in edge release
    t_level();
    t_wake(1'b1);
    t_wake(1'b0);
    t_dog_reset();
    print_verdict();
  end
endmodule : tb
